//--- inc/wam_cfg.svh
// Constants for the waveform auto-measure engine
`ifndef WAM_CFG_SVH
`define WAM_CFG_SVH
`define WAM_CODE_MIN 8'h00
`define WAM_CODE_MAX 8'hFF
`define WAM_MIN_BIN 16'h0019
`define WAM_PCT_LO 8'h0A
`define WAM_PCT_MID 8'h32
`define WAM_PCT_HI 8'h5A
`define WAM_PCT_FULL 8'h64
`define WAM_FREQ_NUM 32'h3B9ACA00
`define WAM_OP_THR_LAST 4'h2
`define WAM_OP_EV_FIRST 4'h3
`define WAM_OP_LOWX 4'hB
`define WAM_OP_HIGHX 4'hC
`define WAM_OP_LAST 4'hD
`define WAM_DIV_STEPS 6'h20
`define WAM_NUM_EV 8
`define WAM_NUM_MEAS 9
`endif

//--- inc/wam_pkg.sv
// Types for the waveform auto-measure engine
package wam_pkg;
	typedef enum logic [3:0] {WAM_IDLE, WAM_CLEAR, WAM_PASS1, WAM_SCAN, WAM_LEVEL, WAM_DISS, WAM_DWAIT,
		WAM_PASS2, WAM_FINAL} wam_state_t;
	typedef enum int {WAM_M_PERIOD, WAM_M_FREQ, WAM_M_PKPK, WAM_M_RISE, WAM_M_FALL, WAM_M_PWID,
		WAM_M_NWID, WAM_M_PRE, WAM_M_OVER} wam_meas_t;
	typedef logic [7:0] wam_code_t;
endpackage

//--- inc/wam_core_if.sv
// Internal links from the controller to the histogram store and the divider
`timescale 1ns/100ps
interface wam_core_if;
	logic h_clr;
	logic h_inc;
	logic [7:0] h_wr;
	logic [7:0] h_rd;
	logic [15:0] h_cnt;
	logic d_start;
	logic [31:0] d_num;
	logic [31:0] d_den;
	logic d_done;
	logic [31:0] d_quot;
	modport ctl (output h_clr, h_inc, h_wr, h_rd, d_start, d_num, d_den, input h_cnt, d_done, d_quot);
	modport hist (input h_clr, h_inc, h_wr, h_rd, output h_cnt);
	modport div (input d_start, d_num, d_den, output d_done, d_quot);
endinterface

//--- logic/wam_hist.sv
// Occurrence histogram over the 256 quantization codes
`timescale 1ns/100ps
module wam_hist (
	input wire logic clk_sys,
	wam_core_if.hist hif
);
	logic [15:0] bin_mem [256];

	// One bin cleared or bumped per cycle; reads are combinational
	always_ff @(posedge clk_sys) begin
		if (hif.h_clr) begin
			bin_mem[hif.h_wr] <= 16'h0000;
		end else if (hif.h_inc) begin
			bin_mem[hif.h_wr] <= bin_mem[hif.h_wr] + 16'h0001;
		end
	end

	assign hif.h_cnt = bin_mem[hif.h_rd];
endmodule

//--- logic/wam_div.sv
// Sequential restoring divider, 32 by 32 bits
`timescale 1ns/100ps
`include "wam_cfg.svh"
module wam_div (
	input wire logic clk_sys,
	input wire logic rst_n,
	wam_core_if.div dif
);
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [32:0] rem_reg, rem_next;
	logic [31:0] quo_reg, quo_next;
	logic [31:0] den_reg, den_next;
	logic [32:0] rem_sh;

	always_comb begin
		busy_next = busy_reg;
		done_next = 1'b0;
		cnt_next = cnt_reg;
		rem_next = rem_reg;
		quo_next = quo_reg;
		den_next = den_reg;
		rem_sh = {rem_reg[31:0], quo_reg[31]};
		if (dif.d_start && !busy_reg) begin
			busy_next = 1'b1;
			cnt_next = `WAM_DIV_STEPS;
			rem_next = 33'h0;
			quo_next = dif.d_num;
			den_next = dif.d_den;
		end else if (busy_reg) begin
			quo_next = {quo_reg[30:0], 1'b0};
			if (rem_sh >= {1'b0, den_reg}) begin
				rem_next = rem_sh - {1'b0, den_reg};
				quo_next[0] = 1'b1;
			end else begin
				rem_next = rem_sh;
			end
			cnt_next = cnt_reg - 6'h01;
			if (cnt_reg == 6'h01) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			cnt_reg <= 6'h00;
			rem_reg <= 33'h0;
			quo_reg <= 32'h0;
			den_reg <= 32'h0;
		end else begin
			busy_reg <= busy_next;
			done_reg <= done_next;
			cnt_reg <= cnt_next;
			rem_reg <= rem_next;
			quo_reg <= quo_next;
			den_reg <= den_next;
		end
	end

	assign dif.d_done = done_reg;
	assign dif.d_quot = quo_reg;

	// Answer exactly 33 cycles after an accepted start, not one cycle early
	AST_DIV_LATENCY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		dif.d_start && !busy_reg |-> ##32 !done_reg ##1 done_reg)
		else $error("divider answer not 33 cycles after start");
	AST_DIV_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		busy_reg |-> !done_reg)
		else $error("divider answered while still busy");
endmodule

//--- logic/wam_top.sv
// Waveform auto-measure engine: histogram levels, thresholds, nine measurements
// Function
// - Offer period, frequency, peak-to-peak, rise, fall, widths, preshoot and overshoot.
// - Source select chooses which channel record is analysed.
// - Use only samples inside the displayed window.
// - Period and frequency need two same-direction crossings.
// - Positive width needs a complete high pulse, negative a low one.
// - Rise items need a rising edge, fall items a falling edge.
// - Clipped signal yields no valid results.
// - Use the earliest qualifying cycle, edge or pulse.
// - Find top and base first, then derive 10, 50 and 90 percent levels.
// - Rise and fall use 10/90 levels; period, frequency, widths use 50.
// - All but peak-to-peak are relative to top and base.
// - Samples are 8-bit codes, 256 histogram levels.
// - Histogram counts every displayed sample's code.
// - Top is busiest upper-half code, base busiest lower-half code.
// - Bins under 5 percent of 500 fall back to maximum and minimum.
// - Period spans first two crossings of the first edge's direction; frequency is reciprocal.
// - Peak-to-peak is maximum minus minimum displayed code.
// - Positive width runs rising 50 crossing to following falling one.
// - Negative width is the first complete low pulse at 50 percent.
// - Rise time is 90 crossing minus 10 crossing on first rising edge.
// - Fall time is 10 crossing minus 90 crossing on first falling edge.
// - Preshoot is pre-edge excursion times 100 over span.
// - Overshoot is post-edge excursion times 100 over span.
`timescale 1ns/100ps
`include "wam_cfg.svh"
module wam_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic meas_start,
	input wire logic [1:0] src_sel,
	input wire logic [14:0] win_first,
	input wire logic [15:0] win_len,
	input wire logic [15:0] samp_period_ps,
	output logic rec_rd_en,
	output logic [1:0] rec_chan,
	output logic [14:0] rec_addr,
	input wire logic [7:0] rec_data,
	output logic busy,
	output logic meas_done,
	output logic clipped,
	output logic [7:0] top_level,
	output logic [7:0] base_level,
	output logic [8:0][31:0] meas_value,
	output logic [8:0] meas_valid
);
	wam_core_if cif ();
	wam_hist u_hist (.clk_sys(clk_sys), .hif(cif.hist));
	wam_div u_div (.clk_sys(clk_sys), .rst_n(rst_n), .dif(cif.div));

	// ==========================================
	// Decoding helpers
	function automatic logic xing(input logic rise, input logic [7:0] thr, input logic [7:0] a,
		input logic [7:0] b);
		xing = rise ? (a < thr && b >= thr) : (a >= thr && b < thr);
	endfunction

	function automatic logic [31:0] to_ps(input logic [23:0] t, input logic [15:0] sp);
		logic [39:0] p;
		p = 40'(t) * 40'(sp);
		to_ps = p[39:8];
	endfunction

	function automatic logic ev_rise(input int e);
		ev_rise = (e < 2) || (e == 4) || (e == 5);
	endfunction

	function automatic logic [1:0] ev_lvl(input int e);
		ev_lvl = (e == 4 || e == 7) ? 2'h0 : ((e == 5 || e == 6) ? 2'h2 : 2'h1);
	endfunction

	// ==========================================
	// State
	wam_pkg::wam_state_t st_reg, st_next;
	logic [1:0] src_reg, src_next;
	logic [14:0] wf_reg, wf_next;
	logic [15:0] wl_reg, wl_next, pos_reg, pos_next, got_reg, got_next;
	logic rv_reg, rv_next, clip_reg, clip_next, done_reg, done_next;
	logic [7:0] prev_reg, prev_next, min_reg, min_next, max_reg, max_next, bin_reg, bin_next;
	logic [7:0] top_reg, top_next, base_reg, base_next;
	logic [15:0] tcnt_reg, tcnt_next, bcnt_reg, bcnt_next;
	logic [7:0] thr_reg [3], thr_next [3];
	logic [3:0] op_reg, op_next;
	logic [7:0] ev_ok_reg, ev_ok_next, ev_hit;
	logic [15:0] ev_idx_reg [8], ev_idx_next [8];
	logic [7:0] ev_a_reg [8], ev_a_next [8], ev_b_reg [8], ev_b_next [8];
	logic [23:0] tk_reg [8], tk_next [8];
	logic [31:0] lowx_reg, lowx_next, highx_reg, highx_next, freq_reg, freq_next;
	logic [8:0][31:0] val_reg, val_next;
	logic [8:0] vld_reg, vld_next;
	logic [7:0] span, mid, ia, ib, ithr;
	logic rise_first, per_ok, pass2_smp;
	logic [23:0] per_tk;
	logic [31:0] per_ps;
	int e_op;

	assign span = top_reg - base_reg;
	assign mid = 8'(({1'b0, min_reg} + {1'b0, max_reg}) >> 1);
	assign pass2_smp = (st_reg == wam_pkg::WAM_PASS2) && rv_reg && (got_reg != 16'h0000);
	// Earliest 50 percent crossing sets the edge direction
	assign rise_first = ev_ok_reg[0] && (!ev_ok_reg[2] || ev_idx_reg[0] < ev_idx_reg[2]);
	assign per_ok = rise_first ? ev_ok_reg[1] : ev_ok_reg[3];
	assign per_tk = rise_first ? tk_reg[1] - tk_reg[0] : tk_reg[3] - tk_reg[2];
	assign per_ps = to_ps(per_tk, samp_period_ps);

	// ==========================================
	// Crossing capture, first occurrence only
	for (genvar e = 0; e < `WAM_NUM_EV; e++) begin : g_ev
		logic dep;
		if (e == 5 || e == 7) begin : g_same
			assign dep = ev_ok_reg[e - 1] | ev_hit[e - 1];
		end else if (e % 2 == 1) begin : g_next
			assign dep = ev_ok_reg[e - 1];
		end else begin : g_free
			assign dep = 1'b1;
		end
		// 50 percent for period and widths, 10/90 for edges
		assign ev_hit[e] = pass2_smp && !ev_ok_reg[e] && dep &&
			xing(ev_rise(e), thr_reg[ev_lvl(e)], prev_reg, rec_data);
	end

	// ==========================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		src_next = src_reg;
		wf_next = wf_reg;
		wl_next = wl_reg;
		pos_next = pos_reg;
		got_next = got_reg;
		rv_next = 1'b0;
		clip_next = clip_reg;
		done_next = 1'b0;
		prev_next = prev_reg;
		min_next = min_reg;
		max_next = max_reg;
		bin_next = bin_reg;
		top_next = top_reg;
		base_next = base_reg;
		tcnt_next = tcnt_reg;
		bcnt_next = bcnt_reg;
		thr_next = thr_reg;
		op_next = op_reg;
		ev_ok_next = ev_ok_reg | ev_hit;
		ev_idx_next = ev_idx_reg;
		ev_a_next = ev_a_reg;
		ev_b_next = ev_b_reg;
		tk_next = tk_reg;
		lowx_next = lowx_reg;
		highx_next = highx_reg;
		freq_next = freq_reg;
		val_next = val_reg;
		vld_next = vld_reg;
		rec_rd_en = 1'b0;
		rec_addr = 15'(wf_reg + pos_reg[14:0]);
		cif.h_clr = 1'b0;
		cif.h_inc = 1'b0;
		cif.h_wr = bin_reg;
		cif.h_rd = bin_reg;
		cif.d_start = 1'b0;
		cif.d_num = 32'h0;
		cif.d_den = 32'h0;
		e_op = int'(op_reg) - int'(`WAM_OP_EV_FIRST);
		ia = ev_a_reg[e_op[2:0]];
		ib = ev_b_reg[e_op[2:0]];
		ithr = thr_reg[ev_lvl(int'(e_op[2:0]))];
		for (int e = 0; e < `WAM_NUM_EV; e++) begin
			if (ev_hit[e]) begin
				ev_idx_next[e] = got_reg;
				ev_a_next[e] = prev_reg;
				ev_b_next[e] = rec_data;
			end
		end
		// Window reads shared by both passes; data returns one cycle later
		if ((st_reg == wam_pkg::WAM_PASS1 || st_reg == wam_pkg::WAM_PASS2) && pos_reg < wl_reg) begin
			rec_rd_en = 1'b1;
			rv_next = 1'b1;
			pos_next = pos_reg + 16'h0001;
		end
		if (rv_reg) begin
			got_next = got_reg + 16'h0001;
			prev_next = rec_data;
		end
		case (st_reg)
			wam_pkg::WAM_IDLE: begin
				if (meas_start) begin
					src_next = src_sel;
					wf_next = win_first;
					wl_next = win_len;
					bin_next = `WAM_CODE_MIN;
					st_next = wam_pkg::WAM_CLEAR;
				end
			end
			wam_pkg::WAM_CLEAR: begin
				cif.h_clr = 1'b1;
				bin_next = bin_reg + 8'h01;
				if (bin_reg == `WAM_CODE_MAX) begin
					pos_next = 16'h0000;
					got_next = 16'h0000;
					min_next = `WAM_CODE_MAX;
					max_next = `WAM_CODE_MIN;
					clip_next = 1'b0;
					st_next = wam_pkg::WAM_PASS1;
				end
			end
			wam_pkg::WAM_PASS1: begin
				cif.h_wr = rec_data;
				if (rv_reg) begin
					cif.h_inc = 1'b1;
					if (rec_data < min_reg) min_next = rec_data;
					if (rec_data > max_reg) max_next = rec_data;
					if (rec_data == `WAM_CODE_MIN || rec_data == `WAM_CODE_MAX) clip_next = 1'b1;
				end
				if (got_next == wl_reg && !rv_next) begin
					bin_next = `WAM_CODE_MIN;
					tcnt_next = 16'h0000;
					bcnt_next = 16'h0000;
					top_next = max_reg;
					base_next = min_reg;
					st_next = wam_pkg::WAM_SCAN;
				end
			end
			wam_pkg::WAM_SCAN: begin
				// Busiest code above and at-or-below the mid code
				if (bin_reg > mid && cif.h_cnt > tcnt_reg) begin
					tcnt_next = cif.h_cnt;
					top_next = bin_reg;
				end
				if (bin_reg <= mid && cif.h_cnt > bcnt_reg) begin
					bcnt_next = cif.h_cnt;
					base_next = bin_reg;
				end
				bin_next = bin_reg + 8'h01;
				if (bin_reg == `WAM_CODE_MAX) st_next = wam_pkg::WAM_LEVEL;
			end
			wam_pkg::WAM_LEVEL: begin
				if (tcnt_reg < `WAM_MIN_BIN || bcnt_reg < `WAM_MIN_BIN) begin
					top_next = max_reg;
					base_next = min_reg;
				end
				op_next = 4'h0;
				st_next = wam_pkg::WAM_DISS;
			end
			wam_pkg::WAM_DISS: begin
				cif.d_start = 1'b1;
				if (op_reg <= `WAM_OP_THR_LAST) begin
					// Fractions of the top-base span
					cif.d_num = 32'(span) * ((op_reg == 4'h0) ? 32'(`WAM_PCT_LO) :
						(op_reg == 4'h1) ? 32'(`WAM_PCT_MID) : 32'(`WAM_PCT_HI));
					cif.d_den = 32'(`WAM_PCT_FULL);
				end else if (op_reg < `WAM_OP_LOWX) begin
					// Linear interpolation between the straddling samples
					cif.d_num = ev_rise(int'(e_op[2:0])) ? {16'h0, 8'(ithr - ia), 8'h00} :
						{16'h0, 8'(ia - ithr), 8'h00};
					cif.d_den = ev_rise(int'(e_op[2:0])) ? 32'(8'(ib - ia)) : 32'(8'(ia - ib));
				end else if (op_reg == `WAM_OP_LOWX) begin
					cif.d_num = 32'(8'(base_reg - min_reg)) * 32'(`WAM_PCT_FULL);
					cif.d_den = 32'(span);
				end else if (op_reg == `WAM_OP_HIGHX) begin
					cif.d_num = 32'(8'(max_reg - top_reg)) * 32'(`WAM_PCT_FULL);
					cif.d_den = 32'(span);
				end else begin
					cif.d_num = `WAM_FREQ_NUM;
					cif.d_den = per_ps;
				end
				st_next = wam_pkg::WAM_DWAIT;
			end
			wam_pkg::WAM_DWAIT: begin
				if (cif.d_done) begin
					if (op_reg <= `WAM_OP_THR_LAST) begin
						thr_next[op_reg[1:0]] = base_reg + cif.d_quot[7:0];
					end else if (op_reg < `WAM_OP_LOWX) begin
						tk_next[e_op[2:0]] = {16'(ev_idx_reg[e_op[2:0]] - 16'h0001), 8'h00} +
							24'(cif.d_quot[8:0]);
					end else if (op_reg == `WAM_OP_LOWX) begin
						lowx_next = cif.d_quot;
					end else if (op_reg == `WAM_OP_HIGHX) begin
						highx_next = cif.d_quot;
					end else begin
						freq_next = cif.d_quot;
					end
					op_next = op_reg + 4'h1;
					st_next = wam_pkg::WAM_DISS;
					if (op_reg == `WAM_OP_THR_LAST) begin
						pos_next = 16'h0000;
						got_next = 16'h0000;
						ev_ok_next = 8'h00;
						st_next = wam_pkg::WAM_PASS2;
					end else if (op_reg == `WAM_OP_LAST) begin
						st_next = wam_pkg::WAM_FINAL;
					end
				end
			end
			wam_pkg::WAM_PASS2: begin
				if (got_next == wl_reg && !rv_next) st_next = wam_pkg::WAM_DISS;
			end
			wam_pkg::WAM_FINAL: begin
				// Nine results, each with its own valid flag
				val_next[wam_pkg::WAM_M_PERIOD] = per_ps;
				vld_next[wam_pkg::WAM_M_PERIOD] = per_ok;
				val_next[wam_pkg::WAM_M_FREQ] = freq_reg;
				vld_next[wam_pkg::WAM_M_FREQ] = per_ok && per_ps != 32'h0;
				val_next[wam_pkg::WAM_M_PKPK] = 32'(8'(max_reg - min_reg));
				vld_next[wam_pkg::WAM_M_PKPK] = 1'b1;
				val_next[wam_pkg::WAM_M_RISE] = to_ps(tk_reg[5] - tk_reg[4], samp_period_ps);
				vld_next[wam_pkg::WAM_M_RISE] = ev_ok_reg[5];
				val_next[wam_pkg::WAM_M_FALL] = to_ps(tk_reg[7] - tk_reg[6], samp_period_ps);
				vld_next[wam_pkg::WAM_M_FALL] = ev_ok_reg[7];
				val_next[wam_pkg::WAM_M_PWID] = to_ps(rise_first ? tk_reg[2] - tk_reg[0] :
					tk_reg[3] - tk_reg[0], samp_period_ps);
				vld_next[wam_pkg::WAM_M_PWID] = rise_first ? ev_ok_reg[2] : (ev_ok_reg[0] && ev_ok_reg[3]);
				val_next[wam_pkg::WAM_M_NWID] = to_ps(rise_first ? tk_reg[1] - tk_reg[2] :
					tk_reg[0] - tk_reg[2], samp_period_ps);
				vld_next[wam_pkg::WAM_M_NWID] = rise_first ? (ev_ok_reg[1] && ev_ok_reg[2]) : ev_ok_reg[0];
				val_next[wam_pkg::WAM_M_PRE] = rise_first ? lowx_reg : highx_reg;
				val_next[wam_pkg::WAM_M_OVER] = rise_first ? highx_reg : lowx_reg;
				vld_next[wam_pkg::WAM_M_PRE] = (ev_ok_reg[0] || ev_ok_reg[2]) && span != 8'h00;
				vld_next[wam_pkg::WAM_M_OVER] = (ev_ok_reg[0] || ev_ok_reg[2]) && span != 8'h00;
				if (clip_reg) vld_next = 9'h000;
				done_next = 1'b1;
				st_next = wam_pkg::WAM_IDLE;
			end
			default: st_next = wam_pkg::WAM_IDLE;
		endcase
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= wam_pkg::WAM_IDLE;
			src_reg <= 2'h0;
			wf_reg <= 15'h0000;
			wl_reg <= 16'h0000;
			pos_reg <= 16'h0000;
			got_reg <= 16'h0000;
			rv_reg <= 1'b0;
			clip_reg <= 1'b0;
			done_reg <= 1'b0;
			prev_reg <= 8'h00;
			min_reg <= 8'h00;
			max_reg <= 8'h00;
			bin_reg <= 8'h00;
			top_reg <= 8'h00;
			base_reg <= 8'h00;
			tcnt_reg <= 16'h0000;
			bcnt_reg <= 16'h0000;
			thr_reg <= '{default: 8'h00};
			op_reg <= 4'h0;
			ev_ok_reg <= 8'h00;
			ev_idx_reg <= '{default: 16'h0000};
			ev_a_reg <= '{default: 8'h00};
			ev_b_reg <= '{default: 8'h00};
			tk_reg <= '{default: 24'h000000};
			lowx_reg <= 32'h0;
			highx_reg <= 32'h0;
			freq_reg <= 32'h0;
			val_reg <= '0;
			vld_reg <= 9'h000;
		end else begin
			st_reg <= st_next;
			src_reg <= src_next;
			wf_reg <= wf_next;
			wl_reg <= wl_next;
			pos_reg <= pos_next;
			got_reg <= got_next;
			rv_reg <= rv_next;
			clip_reg <= clip_next;
			done_reg <= done_next;
			prev_reg <= prev_next;
			min_reg <= min_next;
			max_reg <= max_next;
			bin_reg <= bin_next;
			top_reg <= top_next;
			base_reg <= base_next;
			tcnt_reg <= tcnt_next;
			bcnt_reg <= bcnt_next;
			thr_reg <= thr_next;
			op_reg <= op_next;
			ev_ok_reg <= ev_ok_next;
			ev_idx_reg <= ev_idx_next;
			ev_a_reg <= ev_a_next;
			ev_b_reg <= ev_b_next;
			tk_reg <= tk_next;
			lowx_reg <= lowx_next;
			highx_reg <= highx_next;
			freq_reg <= freq_next;
			val_reg <= val_next;
			vld_reg <= vld_next;
		end
	end

	assign rec_chan = src_reg;
	assign busy = (st_reg != wam_pkg::WAM_IDLE);
	assign meas_done = done_reg;
	assign clipped = clip_reg;
	assign top_level = top_reg;
	assign base_level = base_reg;
	assign meas_value = val_reg;
	assign meas_valid = vld_reg;

	// ==========================================
	// Checks
	sequence s_accept;
		st_reg == wam_pkg::WAM_IDLE && meas_start;
	endsequence
	sequence s_clearing;
		busy && !meas_done [*8];
	endsequence

	AST_START_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_accept |=> s_clearing)
		else $error("engine did not stay busy after start");
	AST_SRC_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_accept |=> rec_chan == $past(src_sel) throughout busy [*3])
		else $error("analysed channel differs from selected source");
	AST_WINDOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rec_rd_en |-> (15'(rec_addr - wf_reg) < wl_reg[14:0] || wl_reg[15]))
		else $error("read outside displayed window");
	AST_CLIP_NOVALID: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_done && clipped |-> meas_valid == 9'h000)
		else $error("valid result on clipped signal");
	AST_THR_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_reg == wam_pkg::WAM_PASS2 |-> base_reg <= thr_reg[0] && thr_reg[0] <= thr_reg[1] &&
		thr_reg[1] <= thr_reg[2] && thr_reg[2] <= top_reg)
		else $error("threshold levels out of order");
	AST_FALLBACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_reg == wam_pkg::WAM_LEVEL && (tcnt_reg < `WAM_MIN_BIN || bcnt_reg < `WAM_MIN_BIN) |=>
		top_reg == max_reg && base_reg == min_reg)
		else $error("sparse bins did not fall back to extremes");
	AST_PKPK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_done |-> meas_value[wam_pkg::WAM_M_PKPK] == 32'(8'(max_reg - min_reg)))
		else $error("peak-to-peak mismatch");
	AST_EDGE_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_ok_reg[5] |-> ev_ok_reg[4] && ev_idx_reg[5] >= ev_idx_reg[4])
		else $error("90 crossing captured before 10 crossing");
	AST_FIRST_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_reg == wam_pkg::WAM_PASS2 && ev_ok_reg[0] |=> $stable(ev_idx_reg[0]))
		else $error("earliest crossing overwritten");
endmodule

//--- tb/wam_rec_model.sv
// Record buffer model: four channels of displayed samples, read latency one cycle
`timescale 1ns/100ps
module wam_rec_model (
	input wire logic clk_sys,
	input wire logic rec_rd_en,
	input wire logic [1:0] rec_chan,
	input wire logic [14:0] rec_addr,
	output logic [7:0] rec_data
);
	logic [7:0] mem [0:3][0:32767];
	initial begin
		rec_data = 8'h00;
	end
	// Between reads the data line toggles so a stale sample never looks valid
	always @(posedge clk_sys) begin
		if (rec_rd_en) begin
			rec_data <= mem[rec_chan][rec_addr];
		end else begin
			rec_data <= ~rec_data;
		end
	end
endmodule

//--- tb/wam_top_tb.sv
// Self-checking testbench for the waveform auto-measure engine
`timescale 1ns/100ps
module wam_top_tb;
	logic clk_sys, rst_n, meas_start, rec_rd_en, busy, meas_done, clipped;
	logic [1:0] src_sel, rec_chan;
	logic [14:0] win_first, rec_addr;
	logic [15:0] win_len, samp_period_ps;
	logic [7:0] rec_data, top_level, base_level;
	logic [8:0][31:0] meas_value;
	logic [8:0] meas_valid;
	int bad_count, samples_checked;
	wam_top wam_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .meas_start(meas_start), .src_sel(src_sel),
		.win_first(win_first), .win_len(win_len), .samp_period_ps(samp_period_ps), .rec_rd_en(rec_rd_en),
		.rec_chan(rec_chan), .rec_addr(rec_addr), .rec_data(rec_data), .busy(busy), .meas_done(meas_done),
		.clipped(clipped), .top_level(top_level), .base_level(base_level), .meas_value(meas_value),
		.meas_valid(meas_valid));
	wam_rec_model wam_rec_model_i (.clk_sys(clk_sys), .rec_rd_en(rec_rd_en), .rec_chan(rec_chan),
		.rec_addr(rec_addr), .rec_data(rec_data));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task stop_test();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Square wave of 100-sample period in the window, clip codes just outside it
	task load(input int ch, input logic [7:0] lo, input logic [7:0] hi, input logic fall_first);
		for (int i = -2; i < 502; i++) begin
			if (i < 0 || i >= 500) begin
				wam_rec_model_i.mem[ch][1000 + i] = 8'hFF;
			end else begin
				wam_rec_model_i.mem[ch][1000 + i] = (((i % 100) >= 50) ^ fall_first) ? hi : lo;
			end
		end
	endtask
	task run(input logic [1:0] ch);
		int n;
		src_sel = ch;
		win_first = 15'h03E8;
		win_len = 16'h01F4;
		meas_start = 1'b1;
		@(posedge clk_sys);
		#1 meas_start = 1'b0;
		for (n = 0; n < 3000; n++) begin
			@(posedge clk_sys);
			#1;
			if (meas_done === 1'b1) break;
		end
		if (n == 3000) begin
			bad_count++;
			stop_test();
		end
	endtask
	// Steps between 20 and E0: thresholds 33/80/CC, 204 ticks per edge
	task expect_square();
		chk(top_level, 32'h000000E0);
		chk(base_level, 32'h00000020);
		chk(clipped, 32'h0);
		chk(meas_value[0], 32'h000C3500);
		chk(meas_value[1], 32'h000004E2);
		chk(meas_value[2], 32'h000000C0);
		chk(meas_value[3], 32'h000018E7);
		chk(meas_value[4], 32'h000018E7);
		chk(meas_value[5], 32'h00061A80);
		chk(meas_value[6], 32'h00061A80);
		chk(meas_value[7], 32'h0);
		chk(meas_value[8], 32'h0);
		chk(meas_valid, 32'h000001FF);
	endtask
	task t_rise_first();
		load(1, 8'h20, 8'hE0, 1'b0);
		run(2'h1);
		expect_square();
		$display("test rise_first done");
	endtask
	task t_fall_first();
		load(2, 8'h20, 8'hE0, 1'b1);
		run(2'h2);
		expect_square();
		$display("test fall_first done");
	endtask
	// Reset in the middle of the first read pass, then outputs back to idle, meas_value checked at index 0 only
	task t_reset_mid();
		load(1, 8'h20, 8'hE0, 1'b0);
		src_sel = 2'h1;
		win_first = 15'h03E8;
		win_len = 16'h01F4;
		meas_start = 1'b1;
		@(posedge clk_sys);
		#1 meas_start = 1'b0;
		repeat (300) @(posedge clk_sys);
		#1;
		chk(busy, 32'h1);
		chk(rec_rd_en, 32'h1);
		chk(rec_chan, 32'h1);
		chk(rec_addr, 32'h00000414);
		rst_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk(busy, 32'h0);
		chk(rec_rd_en, 32'h0);
		chk(rec_addr, 32'h0);
		chk(rec_chan, 32'h0);
		chk(meas_done, 32'h0);
		chk(meas_valid, 32'h0);
		chk(clipped, 32'h0);
		chk(top_level, 32'h0);
		chk(base_level, 32'h0);
		chk(meas_value[0], 32'h0);
		$display("test reset_mid done");
	endtask
	task t_clipped();
		load(3, 8'h20, 8'hFF, 1'b0);
		run(2'h3);
		chk(clipped, 32'h1);
		chk(meas_valid, 32'h0);
		$display("test clipped done");
	endtask
	// Flat trace: empty upper half forces fallback to max and min
	task t_flat();
		load(0, 8'h40, 8'h40, 1'b0);
		run(2'h0);
		chk(top_level, 32'h40);
		chk(base_level, 32'h40);
		chk(meas_value[2], 32'h0);
		chk(meas_valid & 9'h1FB, 32'h0);
		$display("test flat done");
	endtask
	initial begin
		rst_n = 1'b0;
		meas_start = 1'b0;
		src_sel = 2'h0;
		win_first = 15'h0000;
		win_len = 16'h01F4;
		samp_period_ps = 16'h1F40;
		bad_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk(busy, 32'h0);
		t_rise_first();
		t_fall_first();
		t_reset_mid();
		t_clipped();
		t_flat();
		stop_test();
	end
endmodule
